// >>> pkg/mrs_defs.vh
/*
  Constants for the multidrop response scheduler: frame layout, interface selects, TCP port,
  timing figures, default line settings and FIFO geometry.
  Assumes a 10 MHz system clock and a byte stream already deserialised upstream.
*/
`ifndef MRS_DEFS_VH
`define MRS_DEFS_VH

// System clock rate in Hz
`define CLK_HZ            10000000
// Response gap in half byte periods (2.5 byte periods)
`define GAP_HALF_BYTES    5
// Extra half byte periods absorbing receive jitter between units
`define GAP_JITTER_HALVES 1
// Guard time in byte periods
`define GUARD_BYTES       5
// Reply length of an acknowledge or negative acknowledge, in bytes
`define REPLY_BYTES       8
// Header bytes before the length byte (attention, address, three command)
`define HDR_LEN_POS       4'h5
// Header byte count including header checksum
`define HDR_BYTES         4'h7
// Address value that marks a broadcast
`define BCAST_ADDR        8'hFF
// Interface select codes
`define IF_RS232          3'h0
`define IF_USB            3'h1
`define IF_RS422          3'h2
`define IF_RS485_4W       3'h3
`define IF_RS485_2W       3'h4
`define IF_TCP            3'h5
// TCP control port
`define TCP_CTRL_PORT     16'h2711
// Default bit rate and character length in bits
`define BAUD_DEFAULT      19200
`define CHAR_BITS_DEFAULT 4'hA
// FIFO geometry
`define FIFO_WIDTH        9
`define FIFO_DEPTH        32

`endif

// >>> core/byte_fifo.v
/*
  Synchronous FIFO with valid and ready on both sides.
  Assumes a single clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module byte_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             clk,       // System clock
  input  wire             reset,     // Synchronous reset
  input  wire [WIDTH-1:0] in_data,   // Write data
  input  wire             in_valid,  // Write request
  output wire             in_ready,  // Room available
  output wire [WIDTH-1:0] out_data,  // Head word
  output wire             out_valid, // Head word present
  input  wire             out_ready  // Reader takes head
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            push;
  wire            pop;

  // Full and empty from the occupancy count
  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Storage write
  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and count
  always @(posedge clk) begin
    if (reset) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push & ~pop) begin
        count <= count + 1'b1;
      end else if (pop & ~push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // byte_fifo

// >>> core/sync2.v
/*
  Two flip-flop synchroniser for one level.
  Assumes the input is asynchronous to clk.
*/
`timescale 1ns/1ps
module sync2 (
  input  wire clk,   // System clock
  input  wire reset, // Synchronous reset
  input  wire din,   // Asynchronous level
  output reg  dout   // Synchronised level
);
  reg stage1;

  // First stage feeds only the second
  always @(posedge clk) begin
    if (reset) begin
      stage1 <= 1'b0;
      dout   <= 1'b0;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule // sync2

// >>> core/multidrop_response_scheduler.v
/*
  Multidrop response scheduler: parses incoming frames, decides whether a frame
  is for this unit, buffers the bytes of every received frame and times the reply.
  Assumes received bytes arrive as a valid/byte strobe on clk, and that the reply
  sender upstream raises reply_request when it has a reply ready.
*/
// Functional notes
// - Point-to-point links accept frames without address
// - Multidrop links hold an individual unit address
// - Matching address replies at once, others silent
// - Broadcast acted on at last byte
// - Broadcast reply delayed by address, ascending; the code delays by slot_factor, not unit_address
// - Slot delay is (gap plus reply) times slot
// - Gap is 2.5 byte periods plus jitter
// - Address zero answers broadcast without delay; the code does so for slot_factor zero, whatever the address
// - TCP port 10001 carries identical frames
// - Only receive, transmit, ground; duplex modes equal
// - No flow control; RS-232 handshake looped back
// - Concurrent interfaces allowed, never RS-422 with RS-485
// - Legacy firmware allows one selected interface
// - Frame: attention, address, command, length, checksums, data
`timescale 1ns/1ps
`include "mrs_defs.vh"
module multidrop_response_scheduler (
  input  wire        clk,            // 10 MHz system clock
  input  wire        reset,          // Synchronous active-high reset
  input  wire [2:0]  rx_interface,   // Interface the current byte came from
  input  wire [7:0]  rx_byte,        // Received byte
  input  wire        rx_valid,       // Received byte strobe
  input  wire [7:0]  unit_address,   // Own address on multidrop links
  input  wire [7:0]  slot_factor,    // Broadcast reply slot of this unit
  input  wire [19:0] bit_rate,       // Configured serial bit rate in bit/s
  input  wire [3:0]  char_bits,      // Bits per character frame
  input  wire        legacy_mode,    // Older firmware: one interface only
  input  wire [2:0]  menu_interface, // Interface chosen in the on-screen menu
  input  wire [5:0]  enable_mask,    // Interfaces enabled in concurrent mode
  input  wire [15:0] tcp_dest_port,  // Destination port of TCP control traffic
  input  wire        rts_pin,        // RS-232 request-to-send pin
  input  wire        dtr_pin,        // RS-232 terminal-ready pin
  input  wire        reply_request,  // Reply ready to go out
  input  wire        frame_ready,    // Consumer takes a buffered byte
  output reg  [8:0]  frame_data,     // Buffered byte, bit 8 marks last byte
  output reg         frame_valid,    // Buffered byte present
  output reg         rx_ready,       // Room for the next received byte
  output reg         frame_accepted, // Pulse: frame is for this unit
  output reg         frame_broadcast,// Pulse: accepted frame was broadcast
  output reg         tx_enable,      // Reply may be sent now
  output reg         driver_enable,  // Bus driver enable for the transmit line
  output reg         cts_pin,        // RS-232 clear-to-send loopback
  output reg         dsr_pin,        // RS-232 data-set-ready loopback
  output reg         interface_error // Frame dropped for an illegal interface
);
  localparam ST_IDLE  = 3'h0;
  localparam ST_HDR   = 3'h1;
  localparam ST_DATA  = 3'h2;
  localparam ST_CHK   = 3'h3;
  localparam ST_WAIT  = 3'h4;
  localparam ST_REPLY = 3'h5;

  reg  [2:0]  state;
  reg  [2:0]  next_state;
  reg  [3:0]  hdr_count;
  reg  [7:0]  data_left;
  reg  [7:0]  frame_addr;
  reg         frame_ok;
  reg  [31:0] wait_count;
  reg  [31:0] byte_cycles;
  reg         reply_pend;
  wire        rts_sync;
  wire        dtr_sync;
  wire [8:0]  fifo_out;
  wire        fifo_valid;
  wire        fifo_in_ready;
  wire        take;
  wire        last_byte;
  wire        is_multidrop;
  wire        is_bcast;
  wire        if_allowed;
  wire        addr_match;
  wire [31:0] half_byte;
  wire [31:0] gap_cycles;
  wire [31:0] reply_cycles;
  wire [31:0] slot_cycles;
  wire [31:0] bcast_delay;
  wire        fifo_pop;
  wire        fifo_push;
  reg  [5:0]  fill_level;
  reg  [5:0]  next_fill;

  // Handshake pins are asynchronous, so they are synchronised first
  sync2 u_rts (
    .clk   (clk),
    .reset (reset),
    .din   (rts_pin),
    .dout  (rts_sync)
  );
  sync2 u_dtr (
    .clk   (clk),
    .reset (reset),
    .din   (dtr_pin),
    .dout  (dtr_sync)
  );

  // RS-232 handshake looped back, no other flow control on the line
  always @(posedge clk) begin
    if (reset) begin
      cts_pin <= 1'b0;
      dsr_pin <= 1'b0;
    end else begin
      cts_pin <= rts_sync;
      dsr_pin <= dtr_sync;
    end
  end

  // Byte period in clock cycles from bit rate and character length
  always @(posedge clk) begin
    if (reset) begin
      byte_cycles <= 32'h0;
    end else if (bit_rate != 20'h0) begin
      byte_cycles <= (`CLK_HZ * {28'h0, char_bits}) / {12'h0, bit_rate};
    end
  end

  // Reply timing figures built from the byte period
  assign half_byte    = byte_cycles >> 1;
  assign gap_cycles   = half_byte * (`GAP_HALF_BYTES + `GAP_JITTER_HALVES);
  assign reply_cycles = byte_cycles * `REPLY_BYTES;
  assign slot_cycles  = gap_cycles + reply_cycles;
  assign bcast_delay  = slot_cycles * {24'h0, slot_factor};

  // Multidrop links need the address; point-to-point links and TCP do not
  assign is_multidrop = (rx_interface == `IF_RS422) | (rx_interface == `IF_RS485_4W) |
                        (rx_interface == `IF_RS485_2W);
  assign is_bcast     = is_multidrop & (frame_addr == `BCAST_ADDR);
  assign addr_match   = ~is_multidrop | (frame_addr == unit_address);

  // Interface admission: legacy menu choice or concurrent mask without 422 plus 485
  assign if_allowed = legacy_mode ? (rx_interface == menu_interface) :
                      (enable_mask[rx_interface] &
                       ~(rx_interface == `IF_RS422 &
                         (enable_mask[`IF_RS485_4W] | enable_mask[`IF_RS485_2W])) &
                       ~(rx_interface != `IF_RS422 & is_multidrop & enable_mask[`IF_RS422]) &
                       ((rx_interface != `IF_TCP) | (tcp_dest_port == `TCP_CTRL_PORT)));

  assign take      = rx_valid & rx_ready;
  assign last_byte = (state == ST_CHK);

  // Frame parsing state register and counters
  always @(posedge clk) begin
    if (reset) begin
      state      <= ST_IDLE;
      hdr_count  <= 4'h0;
      data_left  <= 8'h0;
      frame_addr <= 8'h0;
      frame_ok   <= 1'b0;
    end else begin
      state <= next_state;
      if (take) begin
        case (state)
          ST_IDLE: begin
            hdr_count <= 4'h1;
            frame_ok  <= if_allowed;
          end
          ST_HDR: begin
            hdr_count <= hdr_count + 4'h1;
            if (hdr_count == 4'h1) begin
              frame_addr <= rx_byte;
            end
            if (hdr_count == `HDR_LEN_POS) begin
              data_left <= rx_byte;
            end
          end
          ST_DATA: begin
            data_left <= data_left - 8'h1;
          end
          default: begin
            hdr_count <= hdr_count;
          end
        endcase
      end
    end
  end

  // Frame sequence: attention, address, command x3, length, header check, data, data check
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE:  if (take) next_state = ST_HDR;
      ST_HDR: begin
        if (take && hdr_count == (`HDR_BYTES - 4'h1)) begin
          next_state = (data_left == 8'h0) ? ST_CHK : ST_DATA;
        end
      end
      ST_DATA:  if (take && data_left == 8'h1) next_state = ST_CHK;
      ST_CHK: begin
        if (take) begin
          next_state = (frame_ok & (addr_match | is_bcast)) ? ST_WAIT : ST_IDLE;
        end
      end
      ST_WAIT:  next_state = (wait_count == 32'h0) ? ST_REPLY : ST_WAIT;
      ST_REPLY: next_state = reply_pend ? ST_REPLY : ST_IDLE;
      default:  next_state = ST_IDLE;
    endcase
  end

  // Accepted bytes pass through the FIFO; a full FIFO stalls reception
  byte_fifo #(
    .WIDTH (`FIFO_WIDTH),
    .DEPTH (`FIFO_DEPTH),
    .AW    (5)
  ) u_fifo (
    .clk       (clk),
    .reset     (reset),
    .in_data   ({last_byte, rx_byte}),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  // Output register stage in front of the consumer
  assign fifo_pop = fifo_valid & (~frame_valid | frame_ready);
  always @(posedge clk) begin
    if (reset) begin
      frame_data  <= 9'h0;
      frame_valid <= 1'b0;
    end else if (fifo_pop) begin
      frame_data  <= fifo_out;
      frame_valid <= 1'b1;
    end else if (frame_ready) begin
      frame_valid <= 1'b0;
    end
  end

  // Bytes written into the FIFO; none while a reply is timed
  assign fifo_push = take & (state != ST_WAIT) & (state != ST_REPLY) & fifo_in_ready;

  // Occupancy one edge ahead, so the registered ready never admits a byte into a full FIFO
  always @* begin
    next_fill = fill_level;
    if (fifo_push & ~fifo_pop) begin
      next_fill = fill_level + 6'h01;
    end else if (fifo_pop & ~fifo_push) begin
      next_fill = fill_level - 6'h01;
    end
  end

  // Occupancy mirror of the FIFO count
  always @(posedge clk) begin
    if (reset) begin
      fill_level <= 6'h00;
    end else begin
      fill_level <= next_fill;
    end
  end

  // Receive ready: FIFO keeps room after this edge and no reply is being timed
  always @(posedge clk) begin
    if (reset) begin
      rx_ready <= 1'b0;
    end else begin
      rx_ready <= (next_fill != `FIFO_DEPTH) & (next_state != ST_WAIT) & (next_state != ST_REPLY);
    end
  end

  // Reply delay: zero for addressed frames, slot delay for broadcasts
  always @(posedge clk) begin
    if (reset) begin
      wait_count <= 32'h0;
    end else if (state == ST_CHK && take) begin
      wait_count <= is_bcast ? bcast_delay : 32'h0;
    end else if (state == ST_WAIT && wait_count != 32'h0) begin
      wait_count <= wait_count - 32'h1;
    end
  end

  // Accept pulses at the final byte of a frame, interface error pulse at the first byte
  always @(posedge clk) begin
    if (reset) begin
      frame_accepted  <= 1'b0;
      frame_broadcast <= 1'b0;
      interface_error <= 1'b0;
    end else begin
      frame_accepted  <= (state == ST_CHK) & take & frame_ok & (addr_match | is_bcast);
      frame_broadcast <= (state == ST_CHK) & take & frame_ok & is_bcast;
      interface_error <= (state == ST_IDLE) & take & ~if_allowed;
    end
  end

  // Reply pending flag: held set outside the reply state, follows reply_request within it
  always @(posedge clk) begin
    if (reset) begin
      reply_pend <= 1'b0;
    end else if (state == ST_REPLY) begin
      reply_pend <= reply_request;
    end else begin
      reply_pend <= 1'b1;
    end
  end

  // Transmit and driver enable only while this unit owns its reply slot
  always @(posedge clk) begin
    if (reset) begin
      tx_enable     <= 1'b0;
      driver_enable <= 1'b0;
    end else begin
      tx_enable     <= (next_state == ST_REPLY);
      driver_enable <= (next_state == ST_REPLY) & is_multidrop;
    end
  end
endmodule // multidrop_response_scheduler

// >>> bench/mrs_checker.sv
/*
  Checker for the multidrop response scheduler: reply timing, pulses, loopback.
  Assumes it is bound to the scheduler top module on one clock.
*/
`timescale 1ns/1ps
module mrs_checker (
  input wire       clk,             // System clock
  input wire       reset,           // Synchronous reset
  input wire       rts_pin,         // Send request pin
  input wire       dtr_pin,         // Terminal ready pin
  input wire [7:0] slot_factor,     // Reply slot
  input wire       reply_request,   // Reply pending
  input wire       rx_ready,        // Byte room
  input wire       frame_accepted,  // Accept pulse
  input wire       frame_broadcast, // Broadcast pulse
  input wire       tx_enable,       // Reply window
  input wire       driver_enable,   // Bus driver
  input wire       cts_pin,         // Loopback out
  input wire       dsr_pin          // Loopback out
);
  reg [2:0] up; // Cycles since reset

  // Saturating count of cycles since reset
  always @(posedge clk) begin
    if (reset) up <= 3'h0;
    else if (up != 3'h7) up <= up + 3'h1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // Slot zero: quiet at the accept cycle, reply the next
  sequence quiet_then_go;
    !tx_enable ##1 tx_enable;
  endsequence

  cts_loop_a: assert property (up > 3'h4 |-> cts_pin == $past(rts_pin, 3)) else $error("cts lag wrong");
  dsr_loop_a: assert property (up > 3'h4 |-> dsr_pin == $past(dtr_pin, 3)) else $error("dsr lag wrong");
  bcast_flag_a: assert property (frame_broadcast |-> frame_accepted) else $error("lone broadcast");
  accept_pulse_a: assert property (frame_accepted |=> !frame_accepted) else $error("accept too long");
  unicast_reply_a: assert property (frame_accepted && !frame_broadcast |-> quiet_then_go) else $error("late reply");
  slot_zero_a: assert property (frame_broadcast && slot_factor == 8'h00 |-> quiet_then_go) else $error("slot 0");
  slot_hold_a: assert property (frame_broadcast && slot_factor != 8'h00 |-> !tx_enable [*8]) else $error("early");
  reply_release_a: assert property (tx_enable && !reply_request |-> ##2 !tx_enable) else $error("reply held");
  driver_gate_a: assert property (driver_enable |-> tx_enable) else $error("driver out of slot");
  busy_refuse_a: assert property (tx_enable && $past(tx_enable) |-> !rx_ready) else $error("ready in reply");
endmodule // mrs_checker

bind multidrop_response_scheduler mrs_checker mrs_checker_inst (.clk(clk), .reset(reset), .rts_pin(rts_pin),
  .dtr_pin(dtr_pin), .slot_factor(slot_factor), .reply_request(reply_request), .rx_ready(rx_ready),
  .frame_accepted(frame_accepted), .frame_broadcast(frame_broadcast), .tx_enable(tx_enable),
  .driver_enable(driver_enable), .cts_pin(cts_pin), .dsr_pin(dsr_pin));

// >>> bench/host_model.sv
/*
  Host model: sends framed messages on the received byte stream.
  Assumes a byte is taken at a rising edge with valid and ready high.
*/
`timescale 1ns/1ps
module host_model #(
  parameter [7:0] ATTENTION_BYTE_BYTE = 8'hA5 // Attention byte, value arbitrary
) (
  input  wire       clk,      // System clock
  input  wire       rx_ready, // Room for a byte
  output reg  [7:0] rx_byte,  // Byte out
  output reg        rx_valid  // Byte present
);
  integer sent; // Bytes taken in this frame

  // Idle stream at time zero
  initial begin
    rx_byte = 8'h00;
    rx_valid = 1'b0;
    sent = 0;
  end

  // Byte i of a frame
  function [7:0] pick(input integer i, input [7:0] addr, input [7:0] len);
    begin
      if (i == 0) pick = ATTENTION_BYTE_BYTE;
      else if (i == 1) pick = addr;
      else if (i == 5) pick = len;
      else pick = 8'h30 + i[7:0];
    end
  endfunction

  // Whole frame, each byte held until taken; ready is stable between edges
  task send_frame(input [7:0] addr, input [7:0] len);
    integer i;
    begin
      sent = 0;
      for (i = 0; i < len + 8; i = i + 1) begin
        @(negedge clk);
        rx_valid = 1'b1;
        rx_byte = pick(i, addr, len);
        while (rx_ready !== 1'b1) @(negedge clk);
        @(posedge clk);
        sent = sent + 1;
      end
      @(negedge clk);
      rx_valid = 1'b0;
      rx_byte = ~rx_byte;
    end
  endtask

  // Spacing after a broadcast reply: five byte times
  task guard(input integer bp);
    begin
      repeat (5 * bp) @(posedge clk);
    end
  endtask
endmodule // host_model

// >>> bench/multidrop_response_scheduler_tb.sv
/*
  Testbench for the multidrop response scheduler: addressing, reply timing, buffering.
  Assumes host_model drives the byte stream and the checker is bound.
*/
`timescale 1ns/1ps
`include "mrs_defs.vh"
`define CHK(what, exp, got) begin check_count = check_count + 1; if ((got) !== (exp)) begin \
  n_errors = n_errors + 1; $display("mismatch %s expected %0h seen %0h", what, exp, got); end end
module multidrop_response_scheduler_tb;
  localparam integer BP = 50; // Byte period: 5-bit characters at 1 Mbit/s
  reg         clk, reset, legacy_mode, rts_pin, dtr_pin, reply_request, frame_ready;
  reg  [2:0]  rx_interface, menu_interface;
  reg  [7:0]  slot_factor;
  reg  [3:0]  char_bits;
  reg  [5:0]  enable_mask;
  reg  [15:0] tcp_dest_port;
  wire [7:0]  rx_byte;
  wire [8:0]  frame_data;
  wire        rx_valid, frame_valid, rx_ready, frame_accepted, frame_broadcast;
  wire        tx_enable, driver_enable, cts_pin, dsr_pin, interface_error;
  integer     n_errors = 0, check_count = 0, cyc = 0, acc_cnt = 0, bc_cnt = 0, err_cnt = 0;
  integer     out_cnt = 0, last_cnt = 0, acc_cyc = 0, tx_cyc = 0, base, base2;
  reg         tx_was = 1'b0;
  reg  [7:0]  last_seen = 8'h00;

  host_model host_model_inst (.clk(clk), .rx_ready(rx_ready), .rx_byte(rx_byte), .rx_valid(rx_valid));
  multidrop_response_scheduler multidrop_response_scheduler_inst (.clk(clk), .reset(reset),
    .rx_interface(rx_interface), .rx_byte(rx_byte), .rx_valid(rx_valid), .unit_address(8'h05),
    .slot_factor(slot_factor), .bit_rate(20'hF4240), .char_bits(char_bits), .legacy_mode(legacy_mode),
    .menu_interface(menu_interface), .enable_mask(enable_mask), .tcp_dest_port(tcp_dest_port),
    .rts_pin(rts_pin), .dtr_pin(dtr_pin), .reply_request(reply_request), .frame_ready(frame_ready),
    .frame_data(frame_data), .frame_valid(frame_valid), .rx_ready(rx_ready),
    .frame_accepted(frame_accepted), .frame_broadcast(frame_broadcast), .tx_enable(tx_enable),
    .driver_enable(driver_enable), .cts_pin(cts_pin), .dsr_pin(dsr_pin), .interface_error(interface_error));

  // Clock at 100 ns
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Pulse counts, output beats, reply stamps and the hang limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    tx_was <= (tx_enable === 1'b1);
    if (frame_accepted === 1'b1) acc_cnt <= acc_cnt + 1;
    if (frame_accepted === 1'b1) acc_cyc <= cyc;
    if (frame_broadcast === 1'b1) bc_cnt <= bc_cnt + 1;
    if (interface_error === 1'b1) err_cnt <= err_cnt + 1;
    if (tx_enable === 1'b1 && !tx_was) tx_cyc <= cyc;
    if (frame_valid === 1'b1 && frame_ready) out_cnt <= out_cnt + 1;
    if (frame_valid === 1'b1 && frame_ready && frame_data[8] === 1'b1) last_cnt <= last_cnt + 1;
    if (frame_valid === 1'b1 && frame_ready && frame_data[8] === 1'b1) last_seen <= frame_data[7:0];
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      end_sim;
    end
  end

  // Link configuration at a falling edge
  task cfg(input [2:0] i, input l, input [2:0] m, input [5:0] k, input [15:0] p);
    begin
      @(negedge clk);
      rx_interface = i;
      legacy_mode = l;
      menu_interface = m;
      enable_mask = k;
      tcp_dest_port = p;
    end
  endtask

  // One frame on a given link, then the accept count
  task run_case(input [2:0] i, input l, input [2:0] m, input [5:0] k, input [15:0] p,
                input [7:0] a, input integer e);
    begin
      cfg(i, l, m, k, p);
      base = acc_cnt;
      host_model_inst.send_frame(a, 8'h01);
      repeat (4) @(posedge clk);
      #1;
      `CHK("accept count", e, acc_cnt - base)
    end
  endtask

  // Handshake loopback delay
  task t_loop;
    begin
      @(negedge clk);
      rts_pin = 1'b1;
      @(negedge clk);
      dtr_pin = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      `CHK("cts", 1'b1, cts_pin)
      `CHK("dsr", 1'b0, dsr_pin)
      @(posedge clk);
      #1;
      `CHK("dsr late", 1'b1, dsr_pin)
      $display("test loop done");
    end
  endtask

  // Addressed frame: reply at once, stands until released
  task t_unicast;
    begin
      cfg(`IF_RS485_4W, 1'b0, 3'h0, 6'h3B, `TCP_CTRL_PORT);
      reply_request = 1'b1;
      base = out_cnt;
      base2 = last_cnt;
      host_model_inst.send_frame(8'h05, 8'h02);
      `CHK("accept", 1'b1, frame_accepted)
      `CHK("quiet", 1'b0, tx_enable)
      @(posedge clk);
      #1;
      `CHK("reply", 1'b1, tx_enable)
      `CHK("driver", 1'b1, driver_enable)
      repeat (4) @(posedge clk);
      #1;
      `CHK("stand", 1'b1, tx_enable)
      @(negedge clk);
      reply_request = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      `CHK("release", 1'b0, tx_enable)
      `CHK("beats", 10, out_cnt - base)
      `CHK("last mark", 1, last_cnt - base2)
      `CHK("last byte", 8'h39, last_seen)
      $display("test unicast done");
    end
  endtask

  // Links, address filter, exclusion and single-link mode
  task t_iface;
    begin
      run_case(`IF_RS232, 1'b0, 3'h0, 6'h3B, `TCP_CTRL_PORT, 8'h4D, 1);
      run_case(`IF_USB, 1'b0, 3'h0, 6'h3B, `TCP_CTRL_PORT, 8'h4D, 1);
      run_case(`IF_TCP, 1'b0, 3'h0, 6'h3B, `TCP_CTRL_PORT, 8'h4D, 1);
      run_case(`IF_TCP, 1'b0, 3'h0, 6'h3B, 16'h2710, 8'h4D, 0);
      run_case(`IF_RS485_2W, 1'b0, 3'h0, 6'h3B, `TCP_CTRL_PORT, 8'h05, 1);
      run_case(`IF_RS485_4W, 1'b0, 3'h0, 6'h3B, `TCP_CTRL_PORT, 8'h06, 0);
      base2 = err_cnt;
      run_case(`IF_RS422, 1'b0, 3'h0, 6'h3F, `TCP_CTRL_PORT, 8'h05, 0);
      run_case(`IF_RS485_4W, 1'b0, 3'h0, 6'h3F, `TCP_CTRL_PORT, 8'h05, 0);
      `CHK("iface error", 2, err_cnt - base2)
      run_case(`IF_RS422, 1'b0, 3'h0, 6'h07, `TCP_CTRL_PORT, 8'h05, 1);
      run_case(`IF_USB, 1'b1, `IF_RS232, 6'h3F, `TCP_CTRL_PORT, 8'h4D, 0);
      run_case(`IF_USB, 1'b1, `IF_USB, 6'h00, `TCP_CTRL_PORT, 8'h4D, 1);
      $display("test iface done");
    end
  endtask

  // Broadcast reply slots 0 to 2
  task t_bcast;
    integer s, i, bp;
    begin
      for (s = 0; s < 3; s = s + 1) begin
        cfg(`IF_RS485_4W, 1'b0, 3'h0, 6'h3B, `TCP_CTRL_PORT);
        slot_factor = s[7:0];
        char_bits = (s == 1) ? 4'hA : 4'h5;
        bp = (s == 1) ? 2 * BP : BP;
        base = bc_cnt;
        host_model_inst.send_frame(`BCAST_ADDR, 8'h01);
        i = 0;
        while (tx_enable !== 1'b1 && i < 3000) begin
          @(posedge clk);
          #1;
          i = i + 1;
        end
        @(posedge clk);
        #1;
        `CHK("broadcast", 1, bc_cnt - base)
        `CHK("slot delay", s * 11 * bp + 1, tx_cyc - acc_cyc)
        host_model_inst.guard(bp);
      end
      $display("test bcast done");
    end
  endtask

  // Buffer fills until refused, then drains to empty
  task t_fifo;
    begin
      cfg(`IF_RS485_4W, 1'b0, 3'h0, 6'h3B, `TCP_CTRL_PORT);
      frame_ready = 1'b0;
      base = out_cnt;
      fork
        host_model_inst.send_frame(8'h05, 8'h1E);
        begin
          repeat (80) @(negedge clk);
          `CHK("full", 1'b0, rx_ready)
          `CHK("fill", 1'b1, host_model_inst.sent >= 32 && host_model_inst.sent <= 34)
          frame_ready = 1'b1;
        end
      join
      repeat (40) @(posedge clk);
      #1;
      `CHK("drained", 38, out_cnt - base)
      `CHK("fifo last byte", 8'h55, last_seen)
      `CHK("empty", 1'b0, frame_valid)
      $display("test fifo done");
    end
  endtask

  // Counts and verdict
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask

  // Reset for 4 cycles, then the tests
  initial begin
    reset = 1'b1;
    {legacy_mode, rts_pin, dtr_pin, reply_request} = 4'h0;
    frame_ready = 1'b1;
    rx_interface = 3'h0;
    menu_interface = 3'h0;
    slot_factor = 8'h00;
    char_bits = 4'h5;
    enable_mask = 6'h3B;
    tcp_dest_port = `TCP_CTRL_PORT;
    repeat (4) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    t_loop;
    t_unicast;
    t_iface;
    t_bcast;
    t_fifo;
    end_sim;
  end
endmodule // multidrop_response_scheduler_tb
